// ### ccf_pkg.sv
// Function
// - clear flag: read as one, write zero
// - zero write after zero read: no change
// - flag set after read survives zero write
// - writing one never changes a flag
// - flag A: pin A edge or match A
// - flag B: pin B edge or match B
// - flag C: pin C edge or match C
// - flag D: pin D edge or match D
// - two low control bits choose capture edge
// - C/D match flags set while buffering
// - wrap flag set on every counter overflow
// - mode select bit: 0 compare, 1 capture
// - unassigned I/O control bits read as one
// - I/O control acts only in timer mode
// - channel pin filters only in capture use
// - trigger filter only in two-phase with trigger
// - buffer bits make C/D buffers of A/B
// - capture moves old A/B into buffer first
package ccf_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] CCF_IDX_MODE = 10'h120;
  localparam logic [9:0] CCF_IDX_STATUS = 10'h123;
  localparam logic [9:0] CCF_IDX_IO_AB = 10'h124;
  localparam logic [9:0] CCF_IDX_IO_CD = 10'h125;
  localparam logic [9:0] CCF_IDX_COUNTER = 10'h126;
  localparam logic [9:0] CCF_IDX_GR_A = 10'h128;
  localparam logic [9:0] CCF_IDX_GR_B = 10'h129;
  localparam logic [9:0] CCF_IDX_GR_C = 10'h12A;
  localparam logic [9:0] CCF_IDX_GR_D = 10'h12B;
  localparam logic [9:0] CCF_IDX_FILTER = 10'h12C;
  localparam logic [9:0] CCF_IDX_CTRL2 = 10'h12D;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CCF_RST_MODE = 8'h48;
  localparam logic [7:0] CCF_RST_IO = 8'h88;
  localparam logic [7:0] CCF_RST_FILTER = 8'h00;
  localparam logic [7:0] CCF_RST_CTRL2 = 8'h00;
  localparam logic [7:0] CCF_STATUS_ONES = 8'h70;
  localparam logic [7:0] CCF_IO_ONES = 8'h88;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CCF_MODE_PWM_B = 0;
  localparam int CCF_MODE_PWM_C = 1;
  localparam int CCF_MODE_PWM_D = 2;
  localparam int CCF_MODE_TWO_PHASE_N = 3;
  localparam int CCF_MODE_BUF_C = 4;
  localparam int CCF_MODE_BUF_D = 5;
  localparam int CCF_MODE_START = 7;
  localparam int CCF_IO_CAP_LO = 2;
  localparam int CCF_IO_CAP_HI = 6;
  localparam int CCF_STAT_WRAP = 7;
  localparam int CCF_FILT_TRIG = 4;
  localparam int CCF_FILT_DIV_LSB = 6;
  localparam int CCF_CTRL2_TRIG_LSB = 6;
  localparam int CCF_FLAG_N = 5;
  localparam int CCF_FLAG_WRAP = 4;
  // ---------------------------------------------------------------
  // edge selections and filter timing
  // ---------------------------------------------------------------
  localparam logic [1:0] CCF_EDGE_RISE = 2'h0;
  localparam logic [1:0] CCF_EDGE_FALL = 2'h1;
  localparam logic [1:0] CCF_EDGE_BOTH = 2'h2;
  localparam logic [1:0] CCF_TRIG_OFF = 2'h0;
  localparam logic [1:0] CCF_TRIG_RISE = 2'h1;
  localparam logic [1:0] CCF_TRIG_FALL = 2'h2;
  localparam logic [5:0] CCF_DIV8_LAST = 6'h07;
  localparam logic [5:0] CCF_DIV32_LAST = 6'h1F;
  localparam logic [5:0] CCF_DIV64_LAST = 6'h3F;
  localparam int CCF_FILT_TAPS = 3;
endpackage : ccf_pkg

// ### ccf_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccf_flag_if;
  import ccf_pkg::*;
  logic [CCF_FLAG_N-1:0] set;
  logic [CCF_FLAG_N-1:0] flags;
  logic [CCF_FLAG_N-1:0] wdata;
  logic rd_take;
  logic wr_take;
  modport keeper (input set, input wdata, input rd_take, input wr_take, output flags);
  modport user (output set, output wdata, output rd_take, output wr_take, input flags);
endinterface : ccf_flag_if
`default_nettype wire

// ### ccf_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_flag_bank
  import ccf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ccf_flag_if.keeper fi
);
  logic [CCF_FLAG_N-1:0] flags_ff;
  logic [CCF_FLAG_N-1:0] seen_ff;
  logic [CCF_FLAG_N-1:0] nxt_flags;
  logic [CCF_FLAG_N-1:0] nxt_seen;
  logic [CCF_FLAG_N-1:0] clr;

  always_comb begin
    // only bits last read as one and now written zero may clear
    clr = fi.wr_take ? (seen_ff & ~fi.wdata) : '0;
    nxt_flags = (flags_ff & ~clr) | fi.set;
    nxt_seen = seen_ff & ~clr;
    if (fi.rd_take) begin
      nxt_seen = seen_ff | flags_ff;
    end
    // a fresh set forgets any earlier read, so a stale clear is lost
    nxt_seen = nxt_seen & ~fi.set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
      seen_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
      seen_ff <= nxt_seen;
    end
  end

  assign fi.flags = flags_ff;
endmodule : ccf_flag_bank
`default_nettype wire

// ### ccf_pin_cond.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_pin_cond
  import ccf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic samp_en,
  input wire logic filt_en,
  input wire logic [1:0] edge_sel,
  output logic edge_evt
);
  logic sync1_ff;
  logic sync2_ff;
  logic [CCF_FILT_TAPS-1:0] taps_ff;
  logic lvl_ff;
  logic prev_ff;
  logic [CCF_FILT_TAPS-1:0] nxt_taps;
  logic nxt_lvl;

  always_comb begin
    nxt_taps = taps_ff;
    nxt_lvl = lvl_ff;
    if (samp_en) begin
      nxt_taps = {taps_ff[CCF_FILT_TAPS-2:0], sync2_ff};
    end
    // filtered level moves only after three equal samples
    if (!filt_en) begin
      nxt_lvl = sync2_ff;
    end else if (&taps_ff) begin
      nxt_lvl = 1'b1;
    end else if (~|taps_ff) begin
      nxt_lvl = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      taps_ff <= '0;
      lvl_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      taps_ff <= nxt_taps;
      lvl_ff <= nxt_lvl;
      prev_ff <= lvl_ff;
    end
  end

  always_comb begin
    unique case (edge_sel)
      CCF_EDGE_RISE: edge_evt = lvl_ff & ~prev_ff;
      CCF_EDGE_FALL: edge_evt = ~lvl_ff & prev_ff;
      default: edge_evt = lvl_ff ^ prev_ff;
    endcase
  end
endmodule : ccf_pin_cond
`default_nettype wire

// ### ccf_timer_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_timer_top
  import ccf_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic channel_pin_a,
  input wire logic channel_pin_b,
  input wire logic channel_pin_c,
  input wire logic channel_pin_d,
  input wire logic external_trigger_pin,
  output logic [CCF_FLAG_N-1:0] event_flags
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] mode_ff;
  logic [7:0] io_ab_ff;
  logic [7:0] io_cd_ff;
  logic [7:0] filter_ff;
  logic [1:0] trig_sel_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] gr_ff [4];
  logic [5:0] div_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [CCF_FLAG_N-1:0] flags_out_ff;

  logic [7:0] nxt_mode;
  logic [7:0] nxt_io_ab;
  logic [7:0] nxt_io_cd;
  logic [7:0] nxt_filter;
  logic [1:0] nxt_trig_sel;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] nxt_gr [4];
  logic [5:0] nxt_div;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;

  ccf_flag_if flag_bus ();

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup;
  logic wr_done;
  logic [9:0] idx;
  logic mapped;
  logic lane0;

  assign setup = psel & ~penable;
  assign wr_done = psel & penable & pready_ff & pwrite;
  assign idx = paddr[11:2];
  assign lane0 = pstrb[0];

  always_comb begin
    unique case (idx)
      CCF_IDX_MODE, CCF_IDX_STATUS, CCF_IDX_IO_AB, CCF_IDX_IO_CD,
      CCF_IDX_COUNTER, CCF_IDX_GR_A, CCF_IDX_GR_B, CCF_IDX_GR_C,
      CCF_IDX_GR_D, CCF_IDX_FILTER, CCF_IDX_CTRL2: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic run;
  logic two_phase;
  logic timer_mode;
  logic buf_c;
  logic buf_d;
  logic [3:0] cap_sel;
  logic [3:0] capture;
  logic [1:0] edge_sel [4];

  assign run = mode_ff[CCF_MODE_START];
  assign two_phase = ~mode_ff[CCF_MODE_TWO_PHASE_N];
  // any channel in pulse-width use occupies register A, so no timer use
  assign timer_mode = ~two_phase & ~mode_ff[CCF_MODE_PWM_B]
    & ~mode_ff[CCF_MODE_PWM_C] & ~mode_ff[CCF_MODE_PWM_D];
  assign buf_c = mode_ff[CCF_MODE_BUF_C];
  assign buf_d = mode_ff[CCF_MODE_BUF_D];
  assign cap_sel = {io_cd_ff[CCF_IO_CAP_HI], io_cd_ff[CCF_IO_CAP_LO],
                    io_ab_ff[CCF_IO_CAP_HI], io_ab_ff[CCF_IO_CAP_LO]};
  // capture selections are honoured only in plain timer mode
  assign capture = timer_mode ? cap_sel : 4'h0;
  assign edge_sel[0] = io_ab_ff[1:0];
  assign edge_sel[1] = io_ab_ff[5:4];
  assign edge_sel[2] = io_cd_ff[1:0];
  assign edge_sel[3] = io_cd_ff[5:4];

  // ---------------------------------------------------------------
  // filter sample divider
  // ---------------------------------------------------------------
  logic samp_en;
  logic [5:0] div_last;

  always_comb begin
    unique case (filter_ff[CCF_FILT_DIV_LSB +: 2])
      2'h0: div_last = 6'h00;
      2'h1: div_last = CCF_DIV8_LAST;
      2'h2: div_last = CCF_DIV32_LAST;
      default: div_last = CCF_DIV64_LAST;
    endcase
    samp_en = (div_ff >= div_last);
    nxt_div = samp_en ? 6'h00 : div_ff + 6'h01;
  end

  // ---------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------
  logic [3:0] pins;
  logic [3:0] pin_evt;
  logic trig_evt_raw;
  logic trig_evt;
  logic trig_on;
  logic [1:0] trig_edge;

  assign pins = {channel_pin_d, channel_pin_c, channel_pin_b, channel_pin_a};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      ccf_pin_cond u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pins[gi]),
        .samp_en(samp_en),
        .filt_en(filter_ff[gi] & capture[gi]),
        .edge_sel(edge_sel[gi]),
        .edge_evt(pin_evt[gi])
      );
    end
  endgenerate

  assign trig_on = two_phase & (trig_sel_ff != CCF_TRIG_OFF);
  always_comb begin
    unique case (trig_sel_ff)
      CCF_TRIG_RISE: trig_edge = CCF_EDGE_RISE;
      CCF_TRIG_FALL: trig_edge = CCF_EDGE_FALL;
      default: trig_edge = CCF_EDGE_BOTH;
    endcase
  end

  ccf_pin_cond u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_trigger_pin),
    .samp_en(samp_en),
    .filt_en(filter_ff[CCF_FILT_TRIG] & trig_on),
    .edge_sel(trig_edge),
    .edge_evt(trig_evt_raw)
  );
  assign trig_evt = trig_evt_raw & trig_on;

  // ---------------------------------------------------------------
  // counter, matches and flag sources
  // ---------------------------------------------------------------
  logic [3:0] match;
  logic wrap;
  logic [3:0] cap_evt;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_match
      // matches are counted only while running, so a parked counter stays quiet
      assign match[gi] = run & (cnt_ff == gr_ff[gi]);
      assign cap_evt[gi] = capture[gi] & pin_evt[gi];
    end
  endgenerate

  assign wrap = run & (&cnt_ff);

  always_comb begin
    flag_bus.set[0] = capture[0] ? pin_evt[0] : match[0];
    flag_bus.set[1] = capture[1] ? pin_evt[1] : match[1];
    flag_bus.set[2] = capture[2] ? pin_evt[2] : match[2];
    flag_bus.set[3] = capture[3] ? pin_evt[3] : match[3];
    flag_bus.set[CCF_FLAG_WRAP] = wrap;
  end

  // marker taken from the same flag values that the read returns
  assign flag_bus.rd_take = setup & ~pwrite & (idx == CCF_IDX_STATUS);
  assign flag_bus.wr_take = wr_done & lane0 & (idx == CCF_IDX_STATUS);
  assign flag_bus.wdata = {pwdata[CCF_STAT_WRAP], pwdata[3:0]};

  ccf_flag_bank u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fi(flag_bus.keeper)
  );

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------
  logic [3:0] gr_wr;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_io_ab = io_ab_ff;
    nxt_io_cd = io_cd_ff;
    nxt_filter = filter_ff;
    nxt_trig_sel = trig_sel_ff;
    nxt_cnt = run ? cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_gr[i] = gr_ff[i];
    end
    gr_wr = 4'h0;
    if (wr_done && lane0) begin
      unique case (idx)
        CCF_IDX_MODE: nxt_mode = pwdata[7:0];
        CCF_IDX_IO_AB: nxt_io_ab = pwdata[7:0];
        CCF_IDX_IO_CD: nxt_io_cd = pwdata[7:0];
        CCF_IDX_FILTER: nxt_filter = pwdata[7:0];
        CCF_IDX_CTRL2: nxt_trig_sel = pwdata[CCF_CTRL2_TRIG_LSB +: 2];
        CCF_IDX_COUNTER: nxt_cnt = pwdata[CNT_W-1:0];
        CCF_IDX_GR_A: gr_wr[0] = 1'b1;
        CCF_IDX_GR_B: gr_wr[1] = 1'b1;
        CCF_IDX_GR_C: gr_wr[2] = 1'b1;
        CCF_IDX_GR_D: gr_wr[3] = 1'b1;
        default: ;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      if (gr_wr[i]) begin
        nxt_gr[i] = pwdata[CNT_W-1:0];
      end
    end
    // hardware transfers win over a software write in the same cycle
    if (cap_evt[0]) begin
      nxt_gr[0] = cnt_ff;
      if (buf_c) begin
        nxt_gr[2] = gr_ff[0];
      end
    end else if (buf_c && !capture[0] && match[0] && !two_phase) begin
      nxt_gr[0] = gr_ff[2];
    end
    if (cap_evt[1]) begin
      nxt_gr[1] = cnt_ff;
      if (buf_d) begin
        nxt_gr[3] = gr_ff[1];
      end
    end else if (buf_d && !capture[1]) begin
      if (two_phase ? (match[0] || trig_evt) : match[1]) begin
        nxt_gr[1] = gr_ff[3];
      end
    end
    // C and D capture on their own only when not serving as buffers
    if (cap_evt[2] && !buf_c) begin
      nxt_gr[2] = cnt_ff;
    end
    if (cap_evt[3] && !buf_d) begin
      nxt_gr[3] = cnt_ff;
    end
  end

  // ---------------------------------------------------------------
  // read data and bus answer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pready = setup;
    nxt_pslverr = setup & ~mapped;
    if (setup && !pwrite) begin
      nxt_prdata = 32'h0000_0000;
      unique case (idx)
        CCF_IDX_MODE: nxt_prdata[7:0] = mode_ff | 8'h40;
        CCF_IDX_STATUS: nxt_prdata[7:0] = CCF_STATUS_ONES
          | {flag_bus.flags[CCF_FLAG_WRAP], 3'h0, flag_bus.flags[3:0]};
        CCF_IDX_IO_AB: nxt_prdata[7:0] = io_ab_ff | CCF_IO_ONES;
        CCF_IDX_IO_CD: nxt_prdata[7:0] = io_cd_ff | CCF_IO_ONES;
        CCF_IDX_COUNTER: nxt_prdata[CNT_W-1:0] = cnt_ff;
        CCF_IDX_GR_A: nxt_prdata[CNT_W-1:0] = gr_ff[0];
        CCF_IDX_GR_B: nxt_prdata[CNT_W-1:0] = gr_ff[1];
        CCF_IDX_GR_C: nxt_prdata[CNT_W-1:0] = gr_ff[2];
        CCF_IDX_GR_D: nxt_prdata[CNT_W-1:0] = gr_ff[3];
        CCF_IDX_FILTER: nxt_prdata[7:0] = filter_ff;
        CCF_IDX_CTRL2: nxt_prdata[CCF_CTRL2_TRIG_LSB +: 2] = trig_sel_ff;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= CCF_RST_MODE;
      io_ab_ff <= CCF_RST_IO;
      io_cd_ff <= CCF_RST_IO;
      filter_ff <= CCF_RST_FILTER;
      trig_sel_ff <= CCF_RST_CTRL2[CCF_CTRL2_TRIG_LSB +: 2];
      cnt_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        gr_ff[i] <= '1;
      end
      div_ff <= 6'h00;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      flags_out_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      io_ab_ff <= nxt_io_ab;
      io_cd_ff <= nxt_io_cd;
      filter_ff <= nxt_filter;
      trig_sel_ff <= nxt_trig_sel;
      cnt_ff <= nxt_cnt;
      for (int i = 0; i < 4; i++) begin
        gr_ff[i] <= nxt_gr[i];
      end
      div_ff <= nxt_div;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      flags_out_ff <= flag_bus.flags;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign event_flags = flags_out_ff;
endmodule : ccf_timer_top
`default_nettype wire

// ### ccf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_checker
  import ccf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic channel_pin_a,
  input wire logic channel_pin_b,
  input wire logic channel_pin_c,
  input wire logic channel_pin_d,
  input wire logic external_trigger_pin,
  input wire logic [CCF_FLAG_N-1:0] event_flags
);
  logic [9:0] idx;
  logic mapped;
  logic [CCF_FLAG_N-1:0] fell;
  assign idx = paddr[11:2];
  assign mapped = idx inside {CCF_IDX_MODE, CCF_IDX_STATUS, CCF_IDX_IO_AB, CCF_IDX_IO_CD,
    CCF_IDX_COUNTER, CCF_IDX_GR_A, CCF_IDX_GR_B, CCF_IDX_GR_C, CCF_IDX_GR_D,
    CCF_IDX_FILTER, CCF_IDX_CTRL2};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_clear_wr;
    s_done ##0 (pwrite && pstrb[0] && idx == CCF_IDX_STATUS);
  endsequence
  property p_ready_cause;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_ready_wait;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not one cycle after setup");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_unmapped_err;
    (s_done ##0 !mapped) |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
  property p_mapped_ok;
    (s_done ##0 mapped) |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  property p_io_ones;
    (s_done ##0 (!pwrite && (idx == CCF_IDX_IO_AB || idx == CCF_IDX_IO_CD)))
      |-> prdata[3] && prdata[7] && prdata[31:8] == 24'h00_0000;
  endproperty
  a_io_ones: assert property (p_io_ones) else $error("io control spare bits wrong");
  property p_status_ones;
    (s_done ##0 (!pwrite && idx == CCF_IDX_STATUS))
      |-> prdata[31:8] == 24'h00_0000 && prdata[6:4] == 3'h7;
  endproperty
  a_status_ones: assert property (p_status_ones) else $error("status spare bits wrong");
  // a flag only drops two edges after a status write with that bit zero
  assign fell = ~event_flags;
  property p_flag_fall;
    (|($past(event_flags) & fell)) |-> $past(psel && penable && pready && pwrite &&
      pstrb[0] && idx == CCF_IDX_STATUS, 2) && (($past(event_flags) & fell &
      {$past(pwdata[7], 2), $past(pwdata[3:0], 2)}) == 5'h00);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag dropped without clear");
  c_clear: cover property (s_clear_wr);
endmodule : ccf_checker
`default_nettype wire

// ### ccf_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccf_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] level_req,
  input wire logic slow,
  output logic [4:0] pins
);
  logic [4:0] d1_ff;
  logic [4:0] d3_ff [2];
  // slow path mimics a sluggish external source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_ff <= 5'h00;
      d3_ff <= '{5'h00, 5'h00};
    end else begin
      d1_ff <= level_req;
      d3_ff <= '{d1_ff, d3_ff[0]};
    end
  end
  assign pins = slow ? d3_ff[1] : d1_ff;
endmodule : ccf_pin_model
`default_nettype wire

// ### tb_capture_compare_flags_io_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_capture_compare_flags_io_ctrl;
  import ccf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] event_flags;
  logic [4:0] pins;
  logic [4:0] level_req = 5'h00;
  logic slow = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  always #2 pclk = ~pclk;
  ccf_timer_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_pin_a(pins[0]), .channel_pin_b(pins[1]),
    .channel_pin_c(pins[2]), .channel_pin_d(pins[3]), .external_trigger_pin(pins[4]),
    .event_flags(event_flags));
  ccf_pin_model i_pins (.pclk(pclk), .presetn(presetn), .level_req(level_req), .slow(slow),
    .pins(pins));
  // ---------------------------------------------------------------
  // bus and pin helpers
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] ix, input logic [15:0] wd,
    output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {16'h0000, wd};
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] ix, input logic [15:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, ix, wd, d, e);
  endtask : wr
  task automatic rd(input logic [9:0] ix, output logic [31:0] d);
    logic e;
    apb(1'b0, ix, 16'h0000, d, e);
  endtask : rd
  task automatic pins_to(input logic [4:0] lv);
    level_req <= lv;
    repeat (12) @(posedge pclk);
  endtask : pins_to
  task automatic stat(input string nm, input logic [31:0] ex);
    logic [31:0] d;
    rd(CCF_IDX_STATUS, d);
    `CHK(nm, ex, d)
  endtask : stat
  task automatic clear_all;
    logic [31:0] d;
    rd(CCF_IDX_STATUS, d);
    wr(CCF_IDX_STATUS, 16'h0000);
  endtask : clear_all
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [9:0] ix [4] = '{CCF_IDX_MODE, CCF_IDX_IO_AB, CCF_IDX_IO_CD, CCF_IDX_STATUS};
    logic [31:0] ex [4] = '{32'h48, 32'h88, 32'h88, 32'h70};
    foreach (ix[i]) begin
      rd(ix[i], d);
      `CHK("reset value", ex[i], d)
    end
    wr(CCF_IDX_IO_AB, 16'h0000);
    rd(CCF_IDX_IO_AB, d);
    `CHK("io ab spare", 32'h88, d)
    $display("test reset done");
  endtask : t_reset
  task automatic t_unmapped;
    logic [31:0] d;
    logic e;
    apb(1'b1, 10'h3FF, 16'h00FF, d, e);
    `CHK("unmapped write err", 1'b1, e)
    apb(1'b0, 10'h3FF, 16'h0000, d, e);
    `CHK("unmapped read data", 32'h0, d)
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_capture;
    logic [31:0] d;
    wr(CCF_IDX_MODE, 16'h0008);
    wr(CCF_IDX_IO_AB, 16'h0054);
    wr(CCF_IDX_IO_CD, 16'h0046);
    slow <= 1'b1;
    pins_to(5'h0F);
    stat("rise flags", 32'h7D);
    `CHK("event flags", 5'h0D, event_flags)
    clear_all();
    stat("cleared", 32'h70);
    pins_to(5'h00);
    stat("fall flags", 32'h76);
    wr(CCF_IDX_STATUS, 16'h00FF);
    stat("one write", 32'h76);
    clear_all();
    rd(CCF_IDX_STATUS, d);
    slow <= 1'b0;
    pins_to(5'h04);
    wr(CCF_IDX_STATUS, 16'h0000);
    stat("late set kept", 32'h74);
    clear_all();
    $display("test capture done");
  endtask : t_capture
  task automatic t_pulse_mode;
    wr(CCF_IDX_MODE, 16'h0009);
    wr(CCF_IDX_IO_AB, 16'h0004);
    pins_to(5'h05);
    stat("pulse mode io", 32'h70);
    $display("test pulse mode done");
  endtask : t_pulse_mode
  task automatic t_compare;
    wr(CCF_IDX_MODE, 16'h0028);
    wr(CCF_IDX_IO_CD, 16'h0000);
    wr(CCF_IDX_COUNTER, 16'hFFF0);
    wr(CCF_IDX_GR_C, 16'hFFFA);
    clear_all();
    wr(CCF_IDX_MODE, 16'h00A8);
    repeat (40) @(posedge pclk);
    wr(CCF_IDX_MODE, 16'h0028);
    stat("match flags", 32'hFE);
    `CHK("event flags", 5'h1E, event_flags)
    $display("test compare done");
  endtask : t_compare
  task automatic t_filter;
    wr(CCF_IDX_FILTER, 16'h0001);
    pins_to(5'h04);
    clear_all();
    level_req <= 5'h05;
    @(posedge pclk);
    level_req <= 5'h04;
    repeat (12) @(posedge pclk);
    stat("filtered glitch", 32'h70);
    pins_to(5'h05);
    stat("filtered edge", 32'h71);
    clear_all();
    $display("test filter done");
  endtask : t_filter
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_capture();
    t_pulse_mode();
    t_compare();
    t_filter();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    conclude();
  end
endmodule : tb_capture_compare_flags_io_ctrl
bind ccf_timer_top ccf_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_pin_a(channel_pin_a),
  .channel_pin_b(channel_pin_b), .channel_pin_c(channel_pin_c),
  .channel_pin_d(channel_pin_d), .external_trigger_pin(external_trigger_pin),
  .event_flags(event_flags));
`default_nettype wire
